//--- verilog/fdsr_pkg.sv
package fdsr_pkg;
	// Register port geometry
	localparam int          ADDR_W        = 4;
	localparam int          DATA_W        = 8;
	localparam int          KEY_BYTES     = 8;
	// Register offsets
	localparam logic [3:0]  OFF_DIVIDER   = 4'h0;
	localparam logic [3:0]  OFF_OPTIONS   = 4'h1;
	localparam logic [3:0]  OFF_CONFIG    = 4'h2;
	localparam logic [3:0]  OFF_KEY_BASE  = 4'h8;
	// Divider field layout
	localparam int          DIV_LOADED_BIT = 7;
	localparam int          DIV_PRE8_BIT   = 6;
	localparam int          DIV_FIELD_W    = 6;
	// Options field layout
	localparam int          OPT_BACKDOOR_KEY_ENABLE_BIT  = 7;
	localparam int          OPT_NORED_BIT  = 6;
	localparam logic [7:0]  OPT_IMPL_MASK  = 8'hC3;
	localparam logic [1:0]  SEC_UNSECURED  = 2'h2;
	// Config field layout
	localparam int          CFG_RW_LSB     = 5;
	localparam int          CFG_KEY_WRITE_ACCESS_BIT = 5;
	// Prescaler
	localparam logic [2:0]  PRE_LAST       = 3'h7;
	// Timing pulse limits and core clock
	localparam int          CORE_PERIOD_NS = 5;
	localparam int          PULSE_MIN_NS   = 5000;
	localparam int          PULSE_MAX_NS   = 6700;
	localparam int          PULSE_MIN_CYC  = (PULSE_MIN_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
	localparam int          PULSE_MAX_CYC  = PULSE_MAX_NS / CORE_PERIOD_NS;

	typedef struct packed {
		logic       divLoaded;
		logic       prescale8;
		logic [5:0] divisor;
		logic [7:0] options;
		logic       optLoaded;
		logic       secure;
		logic [2:0] cfgBits;
		logic [3:0] keyCount;
		logic       keyBad;
		logic [2:0] preCnt;
		logic [5:0] divCnt;
		logic       timingTick;
		logic       cmdStart;
		logic [2:0] cmdIndex;
		logic [7:0] cmdData;
		logic       accErr;
		logic [7:0] rdData;
	} fdsr_state_s;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wrData;
		logic       write;
		logic       read;
		logic       secureSrc;
	} fdsr_req_s;

	// Secure until the options byte says otherwise
	localparam fdsr_state_s STATE_RST = '{secure: 1'b1, default: '0};
endpackage

//--- verilog/fdsr_regs.sv
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module fdsr_regs
(
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   arst_n,
	// Register port
	input  wire fdsr_pkg::fdsr_req_s    regReq,
	output logic [fdsr_pkg::DATA_W-1:0] regRdData,
	// Nonvolatile array side
	input  wire logic [7:0]             nonvolatileOptionsByte,
	input  wire logic [63:0]            storedBackdoorKey,
	input  wire logic                   blankCheckPass,
	// Sequencer side
	output logic                        progEraseEnable,
	output logic                        timingTick,
	output logic                        cmdStart,
	output logic [2:0]                  cmdIndex,
	output logic [7:0]                  cmdData,
	output logic                        accessErrorFlag,
	// Security and vectors
	output logic                        secureActive,
	output logic                        vectorRedirectDisable
);
	import fdsr_pkg::*;

	logic [1:0]  rstSync;
	logic        rstN;
	fdsr_state_s st;
	fdsr_state_s next_st;
	logic [7:0]  keyBuf [KEY_BYTES];
	logic [7:0]  next_keyBuf [KEY_BYTES];
	logic        keyStore;
	logic        keyMatch;
	logic        inKeyWin;
	logic [2:0]  winIdx;
	logic        preWrap;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
		return a == off;
	endfunction

	// Core cycles per flash clock period; 512 at most, so ten bits suffice
	function automatic logic [9:0] tickPeriod(input logic pre8, input logic [5:0] div);
		logic [9:0] base;
		base = {4'h0, div} + 10'h001;
		return pre8 ? {base[6:0], 3'h0} : base;
	endfunction

	// Release of reset through two flops
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rstSync <= 2'h0;
		end else begin
			rstSync <= {rstSync[0], 1'b1};
		end
	end
	assign rstN = rstSync[1];

	assign inKeyWin = regReq.addr[3] == OFF_KEY_BASE[3];
	assign winIdx   = regReq.addr[2:0];

	always_comb begin
		keyMatch = 1'b1;
		for (int i = 0; i < KEY_BYTES; i++) begin
			if (keyBuf[i] != storedBackdoorKey[8*i +: 8]) begin
				keyMatch = 1'b0;
			end
		end
	end

	always_comb begin
		next_st            = st;
		next_st.timingTick = 1'b0;
		next_st.cmdStart   = 1'b0;
		next_st.accErr     = 1'b0;
		next_st.rdData     = 8'h00;
		keyStore           = 1'b0;
		preWrap            = 1'b0;

		// Options byte caught once after reset release
		if (!st.optLoaded) begin
			next_st.options   = nonvolatileOptionsByte & OPT_IMPL_MASK;
			next_st.optLoaded = 1'b1;
		end

		// Divider takes only its first write
		if (regReq.write && hit(regReq.addr, OFF_DIVIDER) && !st.divLoaded) begin
			next_st.divLoaded = 1'b1;
			next_st.prescale8 = regReq.wrData[DIV_PRE8_BIT];
			next_st.divisor   = regReq.wrData[DIV_FIELD_W-1:0];
		end

		// Config write; leaving key mode triggers the compare
		if (regReq.write && hit(regReq.addr, OFF_CONFIG)) begin
			next_st.cfgBits = regReq.wrData[7:CFG_RW_LSB];
			if (st.cfgBits[CFG_KEY_WRITE_ACCESS_BIT-CFG_RW_LSB] && !regReq.wrData[CFG_KEY_WRITE_ACCESS_BIT]) begin
				if (st.options[OPT_BACKDOOR_KEY_ENABLE_BIT] && st.keyCount == 4'(KEY_BYTES) && !st.keyBad
						&& keyMatch) begin
					next_st.options[1:0] = SEC_UNSECURED;
				end
			end
			next_st.keyCount = 4'h0;
			next_st.keyBad   = 1'b0;
		end

		// Key window: key bytes or command launch
		if (regReq.write && inKeyWin) begin
			if (st.cfgBits[CFG_KEY_WRITE_ACCESS_BIT-CFG_RW_LSB]) begin
				if (regReq.secureSrc) begin
					// Bytes must arrive strictly in order
					if (st.keyCount == 4'(KEY_BYTES) || winIdx != st.keyCount[2:0]) begin
						next_st.keyBad = 1'b1;
					end else begin
						keyStore         = 1'b1;
						next_st.keyCount = st.keyCount + 4'h1;
					end
				end
			end else if (st.secure && !regReq.secureSrc) begin
				next_st.cmdStart = 1'b0;
			end else if (!st.divLoaded) begin
				next_st.accErr = 1'b1;
			end else begin
				next_st.cmdStart = 1'b1;
				next_st.cmdIndex = winIdx;
				next_st.cmdData  = regReq.wrData;
			end
		end

		if (blankCheckPass) begin
			next_st.options[1:0] = SEC_UNSECURED;
		end
		next_st.secure = next_st.options[1:0] != SEC_UNSECURED;

		// Flash clock: prescale then divisor plus one
		if (st.divLoaded) begin
			preWrap        = !st.prescale8 || st.preCnt == PRE_LAST;
			next_st.preCnt = preWrap ? 3'h0 : st.preCnt + 3'h1;
			if (preWrap) begin
				if (st.divCnt == st.divisor) begin
					next_st.divCnt     = 6'h00;
					next_st.timingTick = 1'b1;
				end else begin
					next_st.divCnt = st.divCnt + 6'h01;
				end
			end
		end

		// Reads answer one cycle later; unmapped and key window read zero
		if (regReq.read) begin
			unique case (regReq.addr)
				OFF_DIVIDER: next_st.rdData = {st.divLoaded, st.prescale8, st.divisor};
				OFF_OPTIONS: next_st.rdData = st.options & OPT_IMPL_MASK;
				OFF_CONFIG:  next_st.rdData = {st.cfgBits, 5'h00};
				default:     next_st.rdData = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			st <= STATE_RST;
		end else begin
			st <= next_st;
		end
	end

	always_comb begin
		for (int i = 0; i < KEY_BYTES; i++) begin
			next_keyBuf[i] = keyBuf[i];
		end
		if (keyStore) begin
			next_keyBuf[winIdx] = regReq.wrData;
		end
	end

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			for (int i = 0; i < KEY_BYTES; i++) begin
				keyBuf[i] <= 8'h00;
			end
		end else begin
			for (int i = 0; i < KEY_BYTES; i++) begin
				keyBuf[i] <= next_keyBuf[i];
			end
		end
	end

	assign regRdData             = st.rdData;
	assign progEraseEnable       = st.divLoaded;
	assign timingTick            = st.timingTick;
	assign cmdStart              = st.cmdStart;
	assign cmdIndex              = st.cmdIndex;
	assign cmdData               = st.cmdData;
	assign accessErrorFlag       = st.accErr;
	assign secureActive          = st.secure;
	assign vectorRedirectDisable = st.options[OPT_NORED_BIT];

	// Checking helpers: cycles between timing pulses
	logic [9:0] gapCnt;
	logic [9:0] next_gapCnt;
	logic       seenTick;
	logic       next_seenTick;

	always_comb begin
		next_gapCnt   = st.timingTick ? 10'h001 : gapCnt + 10'h001;
		next_seenTick = seenTick | st.timingTick;
	end

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			gapCnt   <= 10'h000;
			seenTick <= 1'b0;
		end else begin
			gapCnt   <= next_gapCnt;
			seenTick <= next_seenTick;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstN);

	a_div_once: assert property (st.divLoaded && regReq.write && hit(regReq.addr, OFF_DIVIDER)
		|=> $stable({st.prescale8, st.divisor})) else $error("divider changed after load");
	a_div_read: assert property (regReq.read && hit(regReq.addr, OFF_DIVIDER)
		|=> regRdData[DIV_LOADED_BIT] == $past(st.divLoaded)) else $error("loaded flag misread");
	a_divisor_loaded_flag_set: assert property (regReq.write && hit(regReq.addr, OFF_DIVIDER)
		|=> progEraseEnable ##1 progEraseEnable) else $error("loaded flag not set");
	a_cmd_gate: assert property (cmdStart |-> $past(st.divLoaded)) else $error("command before divider");
	a_acc_pe: assert property (accessErrorFlag |-> !progEraseEnable) else $error("error while enabled");
	a_pre_wrap: assert property (timingTick && st.prescale8 |-> st.preCnt == 3'h0)
		else $error("prescaler out of step");
	a_tick_gap: assert property (timingTick && seenTick
		|-> gapCnt == tickPeriod(st.prescale8, st.divisor)) else $error("flash clock period wrong");
	a_tick_idle: assert property (!st.divLoaded |=> !timingTick) else $error("tick before load");
	a_tick_pulse: assert property (timingTick && (st.prescale8 || st.divisor != 6'h00)
		|=> !timingTick) else $error("timing pulse too long");
	a_opt_load: assert property (!st.optLoaded
		|=> st.options[7:2] == ($past(nonvolatileOptionsByte[7:2]) & OPT_IMPL_MASK[7:2]))
		else $error("options not loaded");
	a_opt_ro: assert property (st.optLoaded && regReq.write && hit(regReq.addr, OFF_OPTIONS)
		&& !blankCheckPass |=> $stable(st.options)) else $error("options written");
	a_opt_zero: assert property (regReq.read && hit(regReq.addr, OFF_OPTIONS)
		|=> regRdData[5:2] == 4'h0) else $error("options reserved bits set");
	a_key_enable: assert property ($fell(secureActive) && $past(st.optLoaded) && !$past(blankCheckPass)
		|-> $past(st.options[OPT_BACKDOOR_KEY_ENABLE_BIT])) else $error("unlock without key enable");
	a_key_order: assert property (regReq.write && inKeyWin && st.cfgBits[0] && regReq.secureSrc
		&& winIdx != st.keyCount[2:0] |=> st.keyBad) else $error("out of order key accepted");
	a_secure_hold: assert property (!secureActive |=> !secureActive)
		else $error("security came back before reset");
	a_key_secure: assert property (regReq.write && inKeyWin && !regReq.secureSrc
		&& st.cfgBits[0] |=> $stable(st.keyCount)) else $error("debug key write taken");
	a_sec_decode: assert property (st.optLoaded |-> secureActive == (st.options[1:0] != SEC_UNSECURED))
		else $error("security decode wrong");
	a_sec_reset: assert property (!st.optLoaded |-> secureActive) else $error("unsecure before load");
	a_blank_unsec: assert property (blankCheckPass |=> !secureActive ##1 !secureActive)
		else $error("blank check left secure");
	a_cfg_low: assert property (regReq.read && hit(regReq.addr, OFF_CONFIG)
		|=> regRdData[4:0] == 5'h00) else $error("config low bits set");
	a_key_no_cmd: assert property (regReq.write && inKeyWin && st.cfgBits[0]
		|=> !cmdStart) else $error("key byte launched command");
	a_cmd_data: assert property (cmdStart
		|-> cmdData == $past(regReq.wrData) && cmdIndex == $past(regReq.addr[2:0]))
		else $error("command data wrong");
	a_key_count: assert property ($fell(secureActive) && $past(st.optLoaded) && !$past(blankCheckPass)
		|-> $past(st.keyCount) == 4'(KEY_BYTES) && !$past(st.keyBad)) else $error("unlock without full key");
	a_unsec_drop: assert property (regReq.write && inKeyWin && st.secure && !regReq.secureSrc
		|=> !cmdStart && !accessErrorFlag) else $error("unsecured write taken");
	a_acc_err: assert property (regReq.write && inKeyWin && !st.cfgBits[0] && !st.divLoaded
		&& (regReq.secureSrc || !st.secure) |=> accessErrorFlag && !cmdStart)
		else $error("missing access error");
	a_cfg_reset: assert property ($rose(st.optLoaded) |-> st.cfgBits == 3'h0)
		else $error("config not cleared by reset");

	c_unlock_key: cover property (st.cfgBits[0] ##1 !st.cfgBits[0] ##1 !secureActive);
	c_cmd_start: cover property (cmdStart);
	c_acc_err: cover property (accessErrorFlag);
	c_tick_pre8: cover property (timingTick && seenTick && st.prescale8);
	c_key_bad: cover property (st.keyBad && st.cfgBits[0]);
endmodule

//--- bench/fdsr_regs_bench.sv
`timescale 1ns/1ps
module fdsr_regs_bench;
	import fdsr_pkg::*;
	logic       core_clk  = 1'b0;
	logic       arst_n    = 1'b0;
	fdsr_req_s  regReq    = '0;
	logic [7:0] optByte   = 8'h00;
	logic [63:0] key      = '0;
	logic       blankPass = 1'b0;
	logic [7:0] rdData;
	logic [7:0] cmdData;
	logic [2:0] cmdIndex;
	logic       peEn;
	logic       tick;
	logic       cmdStart;
	logic       accErr;
	logic       secure;
	logic       noRedir;
	int         errTotal  = 0;
	int         nTests    = 0;
	int         cyc       = 0;
	int         lastTick  = 0;
	int         tickGap   = 0;
	int         cmdCnt    = 0;
	int         accCnt    = 0;
	int         seed      = 32'hDA9A1BDD;

	fdsr_regs i_dut (
		.core_clk               (core_clk),
		.arst_n                 (arst_n),
		.regReq                 (regReq),
		.regRdData              (rdData),
		.nonvolatileOptionsByte (optByte),
		.storedBackdoorKey      (key),
		.blankCheckPass         (blankPass),
		.progEraseEnable        (peEn),
		.timingTick             (tick),
		.cmdStart               (cmdStart),
		.cmdIndex               (cmdIndex),
		.cmdData                (cmdData),
		.accessErrorFlag        (accErr),
		.secureActive           (secure),
		.vectorRedirectDisable  (noRedir)
	);

	initial begin
		forever #2.5 core_clk = ~core_clk;
	end

	task automatic completeRun;
		if (errTotal == 0 && nTests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Pulse outputs are counted or timed here so no single edge has to be caught
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (tick === 1'b1) begin
			tickGap <= cyc - lastTick;
			lastTick <= cyc;
		end
		if (cmdStart === 1'b1)
			cmdCnt <= cmdCnt + 1;
		if (accErr === 1'b1)
			accCnt <= accCnt + 1;
		if (cyc > 20000) begin
			errTotal++;
			completeRun();
		end
	end

	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		nTests++;
		if (seen !== exp) begin
			errTotal++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic s);
		@(posedge core_clk);
		regReq <= '{addr: a, wrData: d, write: 1'b1, read: 1'b0, secureSrc: s};
		@(posedge core_clk);
		regReq.write <= 1'b0;
	endtask

	task automatic chkRd(input string what, input logic [3:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		regReq <= '{addr: a, wrData: 8'h00, write: 1'b0, read: 1'b1, secureSrc: 1'b1};
		@(posedge core_clk);
		regReq.read <= 1'b0;
		#1;
		check(what, rdData, exp);
	endtask

	task automatic settle;
		repeat (2) @(posedge core_clk);
		#1;
	endtask

	initial begin
		logic [7:0] d;
		logic [7:0] c;
		logic [2:0] idx;
		logic       sb;
		int         cmdExp;
		int         accExp;
		int         per;
		// Passes cover all four security codes and both key-enable values
		for (int p = 0; p < 4; p++) begin
			@(posedge core_clk);
			d = $random(seed);
			d[7] = (p != 2);
			d[1:0] = p[1:0] ^ 2'b10;
			optByte <= d;
			key <= {$random(seed), $random(seed)};
			arst_n <= 1'b0;
			repeat (4) @(posedge core_clk);
			arst_n <= 1'b1;
			repeat (4) @(posedge core_clk);
			#1;
			check("secure", secure, optByte[1:0] != 2'b10);
			check("redirect", noRedir, optByte[6]);
			check("progEnable", peEn, 1'b0);
			chkRd("options", OFF_OPTIONS, optByte & 8'hC3);
			wr(OFF_OPTIONS, ~optByte, 1'b1);
			chkRd("options", OFF_OPTIONS, optByte & 8'hC3);
			chkRd("divider", OFF_DIVIDER, 8'h00);
			chkRd("config", OFF_CONFIG, 8'h00);
			accExp = accCnt + 1;
			cmdExp = cmdCnt;
			wr(OFF_KEY_BASE, 8'h5A, 1'b1);
			settle();
			check("accErr", accCnt, accExp);
			check("cmdBlocked", cmdCnt, cmdExp);
			c = $random(seed);
			wr(OFF_CONFIG, c, 1'b1);
			chkRd("config", OFF_CONFIG, c & 8'hE0);
			wr(OFF_CONFIG, 8'h00, 1'b1);
			// Window of 150 to 200 kHz is out of reach at this core clock; short periods stand in
			d = $random(seed) & 8'hCF;
			wr(OFF_DIVIDER, d, 1'b1);
			chkRd("divider", OFF_DIVIDER, {1'b1, d[6:0]});
			wr(OFF_DIVIDER, ~d, 1'b1);
			chkRd("divider", OFF_DIVIDER, {1'b1, d[6:0]});
			check("progEnable", peEn, 1'b1);
			per = (d[5:0] + 1) * (d[6] ? 8 : 1);
			repeat (4 * per + 4) @(posedge core_clk);
			#1;
			check("tickGap", tickGap, per);
			cmdExp = cmdCnt + 1;
			idx = $random(seed);
			c = $random(seed);
			wr({1'b1, idx}, c, 1'b1);
			settle();
			check("cmdStart", cmdCnt, cmdExp);
			check("cmdIndex", cmdIndex, idx);
			check("cmdData", cmdData, c);
			sb = (optByte[1:0] != 2'b10);
			cmdExp = cmdCnt + (sb ? 0 : 1);
			wr({1'b1, ~idx}, ~c, 1'b0);
			settle();
			check("unsecuredCmd", cmdCnt, cmdExp);
			cmdExp = cmdCnt;
			if (p == 1) begin
				// Reverse order must not unlock
				wr(OFF_CONFIG, 8'h20, 1'b1);
				for (int i = 7; i >= 0; i--)
					wr(4'h8 + i[3:0], key[8*i +: 8], 1'b1);
				wr(OFF_CONFIG, 8'h00, 1'b1);
				settle();
				check("keyOrder", secure, 1'b1);
			end
			wr(OFF_CONFIG, 8'h20, 1'b1);
			for (int i = 0; i < 8; i++)
				wr(4'h8 + i[3:0], key[8*i +: 8], p != 3);
			wr(OFF_CONFIG, 8'h00, 1'b1);
			settle();
			check("keyNoCmd", cmdCnt, cmdExp);
			check("keyUnlock", secure, sb && !(optByte[7] && p != 3));
			if (p == 2) begin
				@(posedge core_clk);
				blankPass <= 1'b1;
				@(posedge core_clk);
				blankPass <= 1'b0;
				settle();
				check("blankUnlock", secure, 1'b0);
			end
		end
		completeRun();
	end
endmodule
